//--- include/ibp_pkg.sv
// shared types and constants of the two-wire bus protocol engine
package ibp_pkg;

  // timing
  localparam int         CLK_PERIOD_NS = 50;
  localparam int         SCL_HALF_NS   = 5000;
  localparam int         HOLD_SHORT_NS = 50;
  localparam int         HOLD_LONG_NS  = 300;
  localparam logic [7:0] SCL_HALF_CYC  = 8'((SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] HOLD_SHORT_CYC = 3'((HOLD_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] HOLD_LONG_CYC  = 3'((HOLD_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // framing
  localparam logic [3:0] ACK_BIT_IDX   = 4'h8;
  localparam int         RX_FIFO_DEPTH = 8;

  // master commands
  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_WRITE = 2'h1,
    OP_READ  = 2'h2,
    OP_STOP  = 2'h3
  } ibp_op_t;

  typedef struct packed {
    ibp_op_t    op;
    logic [7:0] data;
    logic       nack;
  } ibp_cmd_t;

  typedef struct packed {
    logic       fromSlave;
    logic [7:0] data;
  } ibp_rx_t;

  typedef enum logic [6:0] {
    M_IDLE   = 7'h01,
    M_START  = 7'h02,
    M_LOW    = 7'h04,
    M_HIGH   = 7'h08,
    M_RSTART = 7'h10,
    M_STOP   = 7'h20,
    M_LOST   = 7'h40
  } ibp_mstate_t;

  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_ADDR  = 6'h02,
    S_RX    = 6'h04,
    S_ACK   = 6'h08,
    S_TX    = 6'h10,
    S_TXACK = 6'h20
  } ibp_sstate_t;

  typedef struct packed {
    ibp_mstate_t mState;
    logic [7:0]  mTimer;
    logic [1:0]  mPhase;
    logic [3:0]  mBit;
    logic [7:0]  mShift;
    logic        mRead;
    logic        mNack;
    logic        mOwn;
    logic        mSclLow;
    logic        mSdaLow;
    logic        mPush;
    logic        ackStatus;
    ibp_sstate_t sState;
    logic [3:0]  sBit;
    logic [7:0]  sShift;
    logic [7:0]  sRxData;
    logic        sRw;
    logic        sPend;
    logic [2:0]  sHold;
    logic        sSdaLow;
    logic        sSclLow;
    logic        sPush;
    logic        sNack;
    logic        sclP;
    logic        sdaP;
    logic        busBusy;
    logic        sawLow;
    logic        busIdle;
    logic        arbLost;
    logic        busCollision;
    logic        slaveTxTaken;
    logic        startSeen;
    logic        stopSeen;
  } ibp_state_t;

  localparam ibp_state_t ST_RESET = '{mState: M_IDLE, sState: S_IDLE, sclP: 1'b1,
                                      sdaP: 1'b1, default: '0};

endpackage : ibp_pkg

//--- hdl/ibp_sync.sv
// two-flop synchroniser for the bus pins
module ibp_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // levels
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  import ibp_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } ibp_sync_state_t;

  ibp_sync_state_t syncReg;
  ibp_sync_state_t syncNext;

  always_comb
  begin
    syncNext    = syncReg;
    syncNext.s1 = din;
    syncNext.s2 = syncReg.s1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      syncReg <= '1;
    else
      syncReg <= syncNext;
  end

  assign dout = syncReg.s2;

endmodule : ibp_sync

//--- hdl/ibp_fifo.sv
// flop-based fifo with valid and ready on both sides
module ibp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  import ibp_pkg::*;

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr;
    logic [AW:0]                 rd;
  } ibp_fifo_state_t;

  ibp_fifo_state_t fifoReg;
  ibp_fifo_state_t fifoNext;
  logic            full;
  logic            empty;

  assign empty    = fifoReg.wr == fifoReg.rd;
  assign full     = (fifoReg.wr[AW] != fifoReg.rd[AW]) &&
                    (fifoReg.wr[AW-1:0] == fifoReg.rd[AW-1:0]);
  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = fifoReg.mem[fifoReg.rd[AW-1:0]];

  always_comb
  begin
    fifoNext = fifoReg;
    if (inValid && !full)
    begin
      fifoNext.mem[fifoReg.wr[AW-1:0]] = inData;
      fifoNext.wr                      = fifoReg.wr + {{AW{1'b0}}, 1'b1};
    end
    if (outReady && !empty)
      fifoNext.rd = fifoReg.rd + {{AW{1'b0}}, 1'b1};
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      fifoReg <= '0;
    else
      fifoReg <= fifoNext;
  end

endmodule : ibp_fifo

//--- hdl/ibp_engine.sv
// two-wire bus protocol engine: master, addressed slave, bus monitor
module ibp_engine (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // bus pins
  input  wire logic              sclIn,
  output logic                   sclOut,
  output logic                   sclOe,
  input  wire logic              sdaIn,
  output logic                   sdaOut,
  output logic                   sdaOe,
  // configuration
  input  wire logic              portModuleEnable,
  input  wire logic              dataLongHoldSelect,
  input  wire logic [7:0]        slaveMatchAddress,
  // master commands
  input  wire logic              cmdValid,
  output logic                   cmdReady,
  input  wire ibp_pkg::ibp_cmd_t cmd,
  // slave transmit data
  input  wire logic [7:0]        slaveTxData,
  output logic                   slaveTxTaken,
  // received bytes
  output logic                   rxValid,
  input  wire logic              rxReady,
  output ibp_pkg::ibp_rx_t       rxWord,
  // status
  output logic                   busIdle,
  output logic                   masterOwnsBus,
  output logic                   ackStatus,
  output logic                   arbLost,
  output logic                   busCollision,
  output logic                   slaveAddressed,
  output logic                   slaveReading,
  output logic                   startSeen,
  output logic                   stopSeen
);
  import ibp_pkg::*;

  ibp_state_t stReg;
  ibp_state_t stNext;
  logic [1:0] pinSync;
  logic       sclS;
  logic       sdaS;
  logic       sclRise;
  logic       sclFall;
  logic       startDet;
  logic       stopDet;
  logic [2:0] holdCyc;
  logic       pushValid;
  logic       pushReady;
  ibp_rx_t    pushWord;

  // level the master drives on SDA for the current bit
  function automatic logic masterDriveLow(input ibp_state_t s);
    if (s.mBit < ACK_BIT_IDX)
      return !s.mRead && !s.mShift[7];
    return s.mRead && !s.mNack;
  endfunction : masterDriveLow

  // master is transmitter on SDA for the current bit
  function automatic logic masterTransmits(input ibp_state_t s);
    return (s.mBit < ACK_BIT_IDX) ? !s.mRead : s.mRead;
  endfunction : masterTransmits

  ibp_sync #(
    .WIDTH (2)
  ) uSync (
    .clk  (clk),
    .rst  (rst),
    .din  ({sclIn, sdaIn}),
    .dout (pinSync)
  );

  ibp_fifo #(
    .WIDTH ($bits(ibp_rx_t)),
    .DEPTH (RX_FIFO_DEPTH)
  ) uRxFifo (
    .clk      (clk),
    .rst      (rst),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inData   (pushWord),
    .outValid (rxValid),
    .outReady (rxReady),
    .outData  (rxWord)
  );

  assign sclS     = pinSync[1];
  assign sdaS     = pinSync[0];
  assign sclRise  = sclS && !stReg.sclP;
  assign sclFall  = !sclS && stReg.sclP;
  assign startDet = sclS && stReg.sclP && stReg.sdaP && !sdaS;
  assign stopDet  = sclS && stReg.sclP && !stReg.sdaP && sdaS && stReg.sawLow;
  assign holdCyc  = dataLongHoldSelect ? HOLD_LONG_CYC : HOLD_SHORT_CYC;

  // master has priority into the receive fifo
  assign pushValid = stReg.mPush || stReg.sPush;
  assign pushWord  = stReg.mPush ? '{fromSlave: 1'b0, data: stReg.mShift}
                                 : '{fromSlave: 1'b1, data: stReg.sRxData};

  // start only on an idle bus or while owning it, others taken while the master is idle with no byte waiting for the fifo, acted on only while owning it
  assign cmdReady = portModuleEnable && (stReg.mState == M_IDLE) && !stReg.mPush &&
                    (cmd.op != OP_START || stReg.mOwn || stReg.busIdle);

  always_comb
  begin
    stNext              = stReg;
    stNext.arbLost      = 1'b0;
    stNext.busCollision = 1'b0;
    stNext.slaveTxTaken = 1'b0;
    stNext.startSeen    = 1'b0;
    stNext.stopSeen     = 1'b0;

    // bus monitor
    stNext.sclP = sclS;
    stNext.sdaP = sdaS;
    if (sclFall)
      stNext.sawLow = 1'b1;
    if (startDet)
    begin
      stNext.busBusy   = 1'b1;
      stNext.sawLow    = 1'b0;
      stNext.startSeen = 1'b1;
    end
    else if (stopDet)
    begin
      stNext.busBusy  = 1'b0;
      stNext.stopSeen = 1'b1;
    end
    stNext.busIdle = !stNext.busBusy && sclS && sdaS;

    // receive fifo handshake
    if (pushValid && pushReady)
    begin
      if (stReg.mPush)
        stNext.mPush = 1'b0;
      else
        stNext.sPush = 1'b0;
    end

    // master
    case (stReg.mState)
      M_IDLE:
      begin
        if (cmdValid && cmdReady)
        begin
          stNext.mTimer = 8'h00;
          stNext.mPhase = 2'h0;
          case (cmd.op)
            OP_START:
            begin
              if (stReg.mOwn)
              begin
                stNext.mState  = M_RSTART;
                stNext.mSdaLow = 1'b0;
              end
              else
              begin
                stNext.mState  = M_START;
                stNext.mSdaLow = 1'b1;
              end
            end
            OP_WRITE, OP_READ:
            begin
              if (stReg.mOwn)
              begin
                stNext.mState = M_LOW;
                stNext.mShift = cmd.data;
                stNext.mRead  = cmd.op == OP_READ;
                stNext.mNack  = cmd.nack;
                stNext.mBit   = 4'h0;
              end
            end
            OP_STOP:
            begin
              if (stReg.mOwn)
              begin
                stNext.mState  = M_STOP;
                stNext.mSdaLow = 1'b1;
              end
            end
            default:
            begin
              stNext.mState = M_IDLE;
            end
          endcase
        end
      end
      M_START:
      begin
        stNext.mTimer = stReg.mTimer + 8'h01;
        if (stReg.mTimer == SCL_HALF_CYC)
        begin
          stNext.mSclLow = 1'b1;
          stNext.mOwn    = 1'b1;
          stNext.mState  = M_IDLE;
        end
      end
      M_LOW:
      begin
        stNext.mTimer = stReg.mTimer + 8'h01;
        if (stReg.mTimer == {5'h00, holdCyc})
          stNext.mSdaLow = masterDriveLow(stReg);
        if (stReg.mTimer == SCL_HALF_CYC)
        begin
          stNext.mSclLow = 1'b0;
          stNext.mTimer  = 8'h00;
          stNext.mState  = M_HIGH;
        end
      end
      M_HIGH:
      begin
        // high time counts only once SCL is seen high
        stNext.mTimer = sclS ? stReg.mTimer + 8'h01 : 8'h00;
        if (sclRise)
        begin
          if (stReg.mBit < ACK_BIT_IDX)
            stNext.mShift = {stReg.mShift[6:0], sdaS};
          else if (!stReg.mRead)
            stNext.ackStatus = sdaS;
          if (masterTransmits(stReg) && !stReg.mSdaLow && !sdaS)
          begin
            stNext.mState       = M_LOST;
            stNext.mSclLow      = 1'b0;
            stNext.mSdaLow      = 1'b0;
            stNext.mOwn         = 1'b0;
            stNext.arbLost      = 1'b1;
            stNext.busCollision = 1'b1;
          end
        end
        if (stNext.mState == M_HIGH && stReg.mTimer == SCL_HALF_CYC)
        begin
          stNext.mSclLow = 1'b1;
          stNext.mTimer  = 8'h00;
          if (stReg.mBit == ACK_BIT_IDX)
          begin
            stNext.mState = M_IDLE;
            stNext.mPush  = stReg.mRead;
          end
          else
          begin
            stNext.mBit   = stReg.mBit + 4'h1;
            stNext.mState = M_LOW;
          end
        end
      end
      M_RSTART, M_STOP:
      begin
        stNext.mTimer = stReg.mTimer + 8'h01;
        if (stReg.mPhase == 2'h1)
          stNext.mTimer = sclS ? stReg.mTimer + 8'h01 : 8'h00;
        if (stReg.mState == M_RSTART && sclRise && !sdaS)
        begin
          stNext.mState       = M_LOST;
          stNext.mSclLow      = 1'b0;
          stNext.mSdaLow      = 1'b0;
          stNext.mOwn         = 1'b0;
          stNext.arbLost      = 1'b1;
          stNext.busCollision = 1'b1;
        end
        else if (stReg.mTimer == SCL_HALF_CYC)
        begin
          stNext.mTimer = 8'h00;
          stNext.mPhase = stReg.mPhase + 2'h1;
          case (stReg.mPhase)
            2'h0:
            begin
              stNext.mSclLow = 1'b0;
            end
            2'h1:
            begin
              stNext.mSdaLow = stReg.mState == M_RSTART;
            end
            default:
            begin
              stNext.mState  = M_IDLE;
              stNext.mSclLow = stReg.mState == M_RSTART;
              stNext.mOwn    = stReg.mState == M_RSTART;
            end
          endcase
        end
      end
      M_LOST:
      begin
        if (stopDet)
          stNext.mState = M_IDLE;
      end
      default:
      begin
        stNext.mState = M_IDLE;
      end
    endcase

    // slave: delayed SDA update after each falling edge while the slave is not idle
    if (stReg.sHold != 3'h0)
    begin
      stNext.sHold = stReg.sHold - 3'h1;
      if (stReg.sHold == 3'h1)
        stNext.sSdaLow = stReg.sPend;
    end

    if (sclRise)
    begin
      case (stReg.sState)
        S_ADDR, S_RX:
        begin
          stNext.sShift = {stReg.sShift[6:0], sdaS};
          stNext.sBit   = stReg.sBit + 4'h1;
        end
        S_TX:
        begin
          if (!stReg.sSdaLow && !sdaS)
          begin
            stNext.sState       = S_IDLE;
            stNext.sSdaLow      = 1'b0;
            stNext.sHold        = 3'h0;
            stNext.busCollision = 1'b1;
          end
          stNext.sShift = {stReg.sShift[6:0], 1'b1};
          stNext.sBit   = stReg.sBit + 4'h1;
        end
        S_TXACK:
        begin
          stNext.sNack = sdaS;
        end
        default:
        begin
          stNext.sNack = stReg.sNack;
        end
      endcase
    end

    if (sclFall && stReg.sState != S_IDLE)
    begin
      stNext.sHold = holdCyc;
      stNext.sPend = 1'b0;
      case (stReg.sState)
        S_ADDR:
        begin
          if (stReg.sBit == ACK_BIT_IDX)
          begin
            if (stReg.sShift[7:1] == slaveMatchAddress[7:1])
            begin
              stNext.sState = S_ACK;
              stNext.sRw    = stReg.sShift[0];
              stNext.sPend  = 1'b1;
            end
            else
              stNext.sState = S_IDLE;
          end
        end
        S_RX:
        begin
          if (stReg.sBit == ACK_BIT_IDX)
          begin
            stNext.sState  = S_ACK;
            stNext.sRxData = stReg.sShift;
            stNext.sPush   = 1'b1;
            stNext.sPend   = 1'b1;
          end
        end
        S_ACK, S_TXACK:
        begin
          stNext.sBit = 4'h0;
          if (stReg.sState == S_TXACK && stReg.sNack)
            stNext.sState = S_IDLE;
          else if (stReg.sRw)
          begin
            stNext.sState       = S_TX;
            stNext.sShift       = slaveTxData;
            stNext.sPend        = !slaveTxData[7];
            stNext.slaveTxTaken = 1'b1;
          end
          else
            stNext.sState = S_RX;
        end
        S_TX:
        begin
          if (stReg.sBit == ACK_BIT_IDX)
            stNext.sState = S_TXACK;
          else
            stNext.sPend = !stReg.sShift[7];
        end
        default:
        begin
          stNext.sState = S_IDLE;
        end
      endcase
    end

    // start or stop resets the slave whatever it was doing
    if (startDet || stopDet)
    begin
      stNext.sState  = startDet ? S_ADDR : S_IDLE;
      stNext.sBit    = 4'h0;
      stNext.sHold   = 3'h0;
      stNext.sSdaLow = 1'b0;
    end

    // stretch SCL while a received byte waits for fifo room
    stNext.sSclLow = stNext.sPush;

    if (!portModuleEnable)
      stNext = ST_RESET;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      stReg <= ST_RESET;
    else
      stReg <= stNext;
  end

  // open-drain pins: data tied to zero, only the enables move
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe  = stReg.mSclLow || stReg.sSclLow;
  assign sdaOe  = stReg.mSdaLow || stReg.sSdaLow;

  assign busIdle        = stReg.busIdle;
  assign masterOwnsBus  = stReg.mOwn;
  assign ackStatus      = stReg.ackStatus;
  assign arbLost        = stReg.arbLost;
  assign busCollision   = stReg.busCollision;
  assign slaveAddressed = (stReg.sState != S_IDLE) && (stReg.sState != S_ADDR);
  assign slaveReading   = slaveAddressed && stReg.sRw;
  assign slaveTxTaken   = stReg.slaveTxTaken;
  assign startSeen      = stReg.startSeen;
  assign stopSeen       = stReg.stopSeen;

endmodule : ibp_engine

//--- verification/ibp_bus_model.sv
// behavioural far-side slave on the shared two-wire bus
module ibp_bus_model #(
  parameter logic [6:0] ADDR = 7'h52,
  parameter logic [7:0] TX   = 8'hC3
) (
  // bus levels
  input  wire logic scl,
  input  wire logic sda,
  // open-drain pulls
  output logic      sclLow,
  output logic      sdaLow
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  logic       again = 1'b0;

  task automatic rx_byte(output logic [7:0] b);
    repeat (8)
    begin
      @(posedge scl) b = {b[6:0], sda};
      @(negedge scl);
    end
  endtask : rx_byte

  task automatic ack_bit();
    #100 sdaLow = 1'b1;
    sclLow = 1'b1;
    #8000 sclLow = 1'b0;
    @(negedge scl) #100 sdaLow = 1'b0;
  endtask : ack_bit

  task automatic tx_byte(output logic a);
    for (int i = 7; i >= 0; i--)
    begin
      #100 sdaLow = !TX[i];
      @(negedge scl);
    end
    #100 sdaLow = 1'b0;
    @(posedge scl) a = sda;
    @(negedge scl);
  endtask : tx_byte

  task automatic serve();
    logic [7:0] b;
    logic       a;
    rx_byte(b);
    if (b[7:1] != ADDR)
      return;
    ack_bit();
    if (b[0])
      do tx_byte(a); while (!a);
    else
      forever
      begin
        rx_byte(b);
        got.push_back(b);
        ack_bit();
      end
  endtask : serve

  initial
  begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
    forever
    begin
      if (!again)
        @(negedge sda iff scl === 1'b1);
      again = 1'b0;
      fork
        serve();
        @(negedge sda iff scl === 1'b1) again = 1'b1;
        @(posedge sda iff scl === 1'b1);
      join_any
      disable fork;
      sclLow = 1'b0;
      sdaLow = 1'b0;
    end
  end
endmodule : ibp_bus_model

//--- verification/ibp_engine_assertions.sv
// concurrent checks on the bus engine ports
module ibp_engine_assertions (
  // clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // pins and control
  input wire logic              sdaIn,
  input wire logic              sclOut,
  input wire logic              sclOe,
  input wire logic              sdaOut,
  input wire logic              sdaOe,
  input wire logic              portModuleEnable,
  input wire logic              cmdValid,
  input wire logic              cmdReady,
  input wire ibp_pkg::ibp_cmd_t cmd,
  // status
  input wire logic              busIdle,
  input wire logic              masterOwnsBus,
  input wire logic              arbLost,
  input wire logic              busCollision,
  input wire logic              startSeen,
  input wire logic              stopSeen
);
  import ibp_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  pins_tied_a: assert property (!sclOut && !sdaOut)
    else $error("pin data not zero");
  enable_release_a: assert property (!portModuleEnable |=> !sclOe && !sdaOe)
    else $error("pins driven while disabled");
  idle_lines_a: assert property ((!sdaIn) [*4] |-> !busIdle)
    else $error("idle with data line low");
  arb_release_a: assert property (arbLost |-> ##[0:1] (!sdaOe && !sclOe))
    else $error("lines kept after loss");
  loser_yields_a: assert property (arbLost |=> !masterOwnsBus)
    else $error("bus kept after loss");
  collision_flag_a: assert property (arbLost |-> busCollision)
    else $error("loss without collision");
  start_busy_a: assert property (startSeen |=> !busIdle)
    else $error("idle after start");
  stop_idle_a: assert property (stopSeen |-> ##[0:4] busIdle)
    else $error("no idle after stop");
  busy_refuse_a: assert property (cmdValid && cmd.op == OP_START && !busIdle
    && !masterOwnsBus |-> !cmdReady)
    else $error("start taken on busy bus");
endmodule : ibp_engine_assertions

bind ibp_engine ibp_engine_assertions u_chk (.clk, .rst, .sdaIn, .sclOut, .sclOe, .sdaOut,
  .sdaOe, .portModuleEnable, .cmdValid, .cmdReady, .cmd, .busIdle, .masterOwnsBus,
  .arbLost, .busCollision, .startSeen, .stopSeen);

//--- verification/ibp_engine_tb_top.sv
// self-checking bench of the bus engine
module ibp_engine_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ibp_pkg::*;
  logic clk = 1'b0, rst = 1'b1, tbScl = 1'b0, tbSda = 1'b0, mScl, mSda, sclW, sdaW;
  logic portModuleEnable = 1'b0, dataLongHoldSelect = 1'b0, cmdValid = 1'b0, rxReady = 1'b0;
  logic sclOe, sdaOe, cmdReady, slaveTxTaken, rxValid, busIdle, masterOwnsBus, ackStatus;
  logic arbLost, busCollision, slaveAddressed, slaveReading, startSeen, stopSeen, a;
  logic [7:0] slaveTxData = 8'h9C, v;
  ibp_cmd_t   cmd = '0;
  ibp_rx_t    rxWord;
  int         n_mismatch = 0, comparisons = 0;

  assign sclW = !(sclOe || mScl || tbScl);
  assign sdaW = !(sdaOe || mSda || tbSda);
  ibp_engine u_dut (.clk, .rst, .sclIn(sclW), .sclOut(), .sclOe, .sdaIn(sdaW), .sdaOut(),
    .sdaOe, .portModuleEnable, .dataLongHoldSelect, .slaveMatchAddress(8'h60), .cmdValid,
    .cmdReady, .cmd, .slaveTxData, .slaveTxTaken, .rxValid, .rxReady, .rxWord, .busIdle,
    .masterOwnsBus, .ackStatus, .arbLost, .busCollision, .slaveAddressed, .slaveReading,
    .startSeen, .stopSeen);
  ibp_bus_model u_partner (.scl(sclW), .sda(sdaW), .sclLow(mScl), .sdaLow(mSda));

  initial
  begin
    forever #25 clk = ~clk;
  end

  task automatic chk_word(input string what, input logic [8:0] exp, input logic [8:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic mcmd(input ibp_op_t op, input logic [7:0] d, input logic nk);
    @(posedge clk);
    cmdValid <= 1'b1;
    cmd <= '{op: op, data: d, nack: nk};
    do @(negedge clk); while (cmdReady !== 1'b1);
    @(posedge clk) cmdValid <= 1'b0;
    do @(negedge clk); while (cmdReady !== 1'b1);
  endtask : mcmd

  task automatic mbit(input logic b, output logic s);
    @(posedge clk) tbScl <= 1'b1;
    repeat (2) @(posedge clk);
    tbSda <= !b;
    repeat (3) @(posedge clk);
    tbScl <= 1'b0;
    do @(posedge clk); while (sclW !== 1'b1);
    @(negedge clk) s = sdaW;
    @(posedge clk);
  endtask : mbit

  task automatic mbyte(input logic [7:0] d, output logic k);
    for (int i = 7; i >= 0; i--)
      mbit(d[i], k);
    mbit(1'b1, k);
  endtask : mbyte

  task automatic mread(input logic nk, output logic [7:0] d);
    for (int i = 0; i < 8; i++)
      mbit(1'b1, d[7 - i]);
    mbit(nk, a);
  endtask : mread

  task automatic mstart();
    @(posedge clk) tbSda <= 1'b1;
    repeat (5) @(posedge clk);
  endtask : mstart

  task automatic mstop();
    @(posedge clk) tbScl <= 1'b1;
    tbSda <= 1'b1;
    repeat (5) @(posedge clk);
    tbScl <= 1'b0;
    repeat (3) @(posedge clk);
    tbSda <= 1'b0;
    repeat (5) @(posedge clk);
  endtask : mstop

  task automatic drain(input logic fs, input logic [7:0] b, input logic [7:0] st, input int n);
    for (int i = 0; i < n; i++)
    begin
      do @(negedge clk); while (rxValid !== 1'b1);
      chk_word("rx word", {fs, b + st * 8'(i)}, rxWord);
      @(posedge clk) rxReady <= 1'b1;
      @(posedge clk) rxReady <= 1'b0;
    end
  endtask : drain

  task automatic t_master_write();
    logic [7:0] wb [3] = '{8'hA4, 8'h5A, 8'h3C};
    dataLongHoldSelect <= 1'b1;
    mcmd(OP_START, 8'h00, 1'b0);
    foreach (wb[i])
    begin
      mcmd(OP_WRITE, wb[i], 1'b0);
      chk_word("write ack", 9'h000, {8'h00, ackStatus});
    end
    mcmd(OP_STOP, 8'h00, 1'b0);
    chk_word("far byte", 9'h05A, {1'b0, u_partner.got.pop_front()});
    chk_word("far byte", 9'h03C, {1'b0, u_partner.got.pop_front()});
    mcmd(OP_START, 8'h00, 1'b0);
    mcmd(OP_WRITE, 8'h22, 1'b0);
    chk_word("no ack", 9'h001, {8'h00, ackStatus});
    mcmd(OP_STOP, 8'h00, 1'b0);
    $display("test master_write done");
  endtask : t_master_write

  task automatic t_master_read();
    mcmd(OP_START, 8'h00, 1'b0);
    mcmd(OP_WRITE, 8'hA4, 1'b0);
    mcmd(OP_WRITE, 8'h01, 1'b0);
    mcmd(OP_START, 8'h00, 1'b0);
    mcmd(OP_WRITE, 8'hA5, 1'b0);
    mcmd(OP_READ, 8'h00, 1'b0);
    mcmd(OP_READ, 8'h00, 1'b1);
    mcmd(OP_STOP, 8'h00, 1'b0);
    drain(1'b0, 8'hC3, 8'h00, 2);
    $display("test master_read done");
  endtask : t_master_read

  task automatic t_arbitration();
    mcmd(OP_START, 8'h00, 1'b0);
    @(posedge clk) tbSda <= 1'b1;
    fork
      mcmd(OP_WRITE, 8'hFF, 1'b0);
      begin
        do @(negedge clk); while (arbLost !== 1'b1);
        chk_word("collision", 9'h001, {8'h00, busCollision});
        repeat (3) @(negedge clk);
        chk_word("loser lines", 9'h000, {7'h00, sclOe, masterOwnsBus});
        @(posedge clk) tbSda <= 1'b0;
      end
    join
    repeat (10) @(negedge clk);
    chk_word("idle", 9'h001, {8'h00, busIdle});
    $display("test arbitration done");
  endtask : t_arbitration

  task automatic t_slave_write();
    mstart();
    mbyte(8'h60, a);
    chk_word("addr ack", 9'h000, {8'h00, a});
    for (int i = 0; i < 8; i++)
      mbyte(8'h10 + 8'(i), a);
    fork
      mbyte(8'h18, a);
      begin
        repeat (120) @(negedge clk);
        chk_word("stretch", 9'h001, {8'h00, sclOe});
        drain(1'b1, 8'h10, 8'h01, 9);
      end
    join
    chk_word("data ack", 9'h000, {8'h00, a});
    mstop();
    $display("test slave_write done");
  endtask : t_slave_write

  task automatic t_slave_read();
    mstart();
    mbyte(8'h62, a);
    chk_word("foreign addr", 9'h001, {8'h00, a});
    mstop();
    mstart();
    mbyte(8'h61, a);
    chk_word("read addr", 9'h002, {7'h00, slaveReading, a});
    mread(1'b0, v);
    chk_word("slave byte", {1'b0, slaveTxData}, {1'b0, v});
    mread(1'b1, v);
    chk_word("slave byte", {1'b0, slaveTxData}, {1'b0, v});
    fork
      mcmd(OP_START, 8'h00, 1'b0);
      begin
        repeat (40) @(negedge clk);
        chk_word("busy wait", 9'h000, {8'h00, masterOwnsBus});
        mstop();
      end
    join
    mcmd(OP_STOP, 8'h00, 1'b0);
    $display("test slave_read done");
  endtask : t_slave_read

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (80000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end

  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    portModuleEnable <= 1'b1;
    t_master_write();
    t_master_read();
    t_arbitration();
    dataLongHoldSelect <= 1'b0;
    t_slave_write();
    t_slave_read();
    tally_and_finish();
  end
endmodule : ibp_engine_tb_top
